// ### udsr_pkg.sv
// Package for the USB device status register block.
// Assumes a single 100 MHz clock domain shared with the USB core.
package udsr_pkg;
    // Command codes on the microcontroller command port
    localparam logic [7:0] CMD_EP_ENABLE = 8'hd8;
    localparam logic [7:0] CMD_READ_INT = 8'hf4;
    localparam logic [7:0] CMD_READ_FRAME = 8'hf5;
    localparam logic [7:0] CMD_SET_STATUS = 8'hfe;
    localparam logic [7:0] CMD_GET_STATUS = 8'hfe;
    localparam logic [7:0] CMD_GET_ERROR = 8'hff;
    localparam logic [7:0] CMD_SEL_CLR_BASE = 8'h40;
    // Field positions
    localparam int EP_ENABLE_BIT = 0;
    localparam int INT_DEV_EVENT_BIT = 7;
    localparam int ST_SUSPEND_BIT = 2;
    localparam int ST_SUSP_CHG_BIT = 3;
    localparam int ST_BUS_RESET_BIT = 4;
    localparam int ERR_FLAG_BIT = 4;
    localparam int NUM_EP = 6;
    // Reset values
    localparam logic [7:0] EP_ENABLE_RESET = 8'h00;
    localparam logic [7:0] INT_SRC_RESET = 8'h00;
    localparam logic [7:0] ERR_RESET = 8'h00;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int IDLE_SUSPEND_US = 3000;
    localparam int IDLE_SUSPEND_CYC = IDLE_SUSPEND_US * CLK_MHZ;
    // Error codes
    typedef enum logic [3:0] {
        ERR_NONE = 4'h0, ERR_PID_ENC = 4'h1, ERR_PID_UNK = 4'h2, ERR_UNEXP = 4'h3,
        ERR_TOKEN_CRC = 4'h4, ERR_DATA_CRC = 4'h5, ERR_TIMEOUT = 4'h6, ERR_BABBLE = 4'h7,
        ERR_EOP = 4'h8, ERR_SENT_NAK = 4'h9, ERR_SENT_STALL = 4'ha, ERR_OVERRUN = 4'hb,
        ERR_RSVD = 4'hc, ERR_BITSTUFF = 4'hd, ERR_SYNC = 4'he, ERR_TOGGLE = 4'hf
    } udsr_err_t;
    // Error report from the protocol engine
    typedef struct packed {
        logic valid;
        udsr_err_t code;
    } udsr_err_rpt_t;
    // Microcontroller command port request
    typedef struct packed {
        logic cmd_valid;
        logic [7:0] cmd;
        logic wr_valid;
        logic [7:0] wr_data;
        logic rd_req;
    } udsr_req_t;
endpackage

// ### udsr_status_regs.sv
// USB device status and diagnostic registers behind a command port.
// Assumes usb side event inputs are synchronous to clk, one-cycle pulses.
`timescale 1ns/10ps

// Overview of operation
// - Enable bit 0 gates non-control end-points; reads zero after reset.
// - Interrupt source: bits 0-5 end-points, bit 6 reserved, bit 7 device event.
// - Reading device status clears the device event interrupt bit.
// - Frame number read as two bytes, low byte first, upper five bits zero.
// - Status: bits 1,0 reserved, bit 2 suspend, bits 3,4 clear-on-read events.
// - Suspend sets after 3 ms idle upstream, clears on any activity.
// - Writing zero to suspend while suspended issues remote wake-up only.
// - Suspend change sets whenever suspend toggles; cleared on status read.
// - Bus reset sets bit, clears on read, returns device to address 0.
// - Error register: code bits 3-0, occurred flag bit 4, zero at reset.
// - Error codes follow the sixteen-entry code table.
// - End-point interrupt bit clears only by select with clear interrupt.
// - Error occurred flag clears at the start of each new transfer.
module udsr_status_regs
    import udsr_pkg::*;
#(
    parameter int IDLE_CYCLES = IDLE_SUSPEND_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire udsr_req_t req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic bus_activity,
    input wire logic bus_reset_evt,
    input wire logic sof_valid,
    input wire logic [10:0] sof_frame,
    input wire logic [NUM_EP-1:0] ep_event,
    input wire logic dev_event,
    input wire udsr_err_rpt_t err_rpt,
    input wire logic transfer_start,
    output logic endpoints_enabled,
    output logic remote_wakeup,
    output logic default_state,
    output logic irq
);
    // Refuse idle limits that the 28-bit idle counter cannot reach
    if (IDLE_CYCLES < 1 || IDLE_CYCLES > 32'h0fff_ffff) begin : g_bad_idle
        $error("IDLE_CYCLES out of range");
    end

    // Refuse end-point counts that collide with the reserved and event bits
    if (NUM_EP < 1 || NUM_EP > 6) begin : g_bad_ep
        $error("NUM_EP out of range");
    end

    // Command latch and register contents
    logic [7:0] cmd_r;
    logic [7:0] ep_en_r;
    logic [7:0] int_src_r;
    logic [10:0] frame_r;
    logic frame_byte_r;

    // Status flags
    logic suspend_r;
    logic susp_chg_r;
    logic bus_rst_r;
    logic [3:0] err_code_r;
    logic err_flag_r;

    // Suspend timing and outgoing pulses
    logic [27:0] idle_cnt_r;
    logic wake_r;
    logic dflt_r;

    // Read path
    logic [7:0] rd_data_r;
    logic rd_valid_r;

    // Decodes shared by several processes
    logic status_read;
    logic suspend_nxt;
    logic suspend_toggle;
    logic [7:0] sel_clr_mask;

    // Status byte assembled from flags
    function automatic logic [7:0] status_byte(logic s, logic c, logic b);
        status_byte = {3'b000, b, c, s, 2'b00};
    endfunction

    // Data strobe aimed at the command latched last
    function automatic logic strobe_for(logic strobe, logic [7:0] cur, logic [7:0] code);
        strobe_for = strobe && cur == code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command latch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmd_r <= 8'h00;
        end else if (req.cmd_valid) begin
            cmd_r <= req.cmd;
        end
    end

    // Frame byte pointer, low byte first
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_byte_r <= 1'b0;
        end else if (req.cmd_valid) begin
            frame_byte_r <= 1'b0;
        end else if (strobe_for(req.rd_req, cmd_r, CMD_READ_FRAME)) begin
            frame_byte_r <= ~frame_byte_r;
        end
    end

    // Data read of the status register, which clears its events
    assign status_read = strobe_for(req.rd_req, cmd_r, CMD_GET_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Read data path
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= req.rd_req;
            if (req.rd_req) begin
                unique case (cmd_r)
                    CMD_READ_INT: rd_data_r <= {int_src_r[7], 1'b0, int_src_r[5:0]};
                    CMD_READ_FRAME: rd_data_r <= frame_byte_r ?
                        {5'b00000, frame_r[10:8]} : frame_r[7:0];
                    CMD_GET_STATUS: rd_data_r <= status_byte(suspend_r, susp_chg_r, bus_rst_r);
                    CMD_GET_ERROR: rd_data_r <= {3'b000, err_flag_r, err_code_r};
                    default: rd_data_r <= 8'h00;
                endcase
            end
        end
    end

    // Read answer straight from flip-flops
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // End-point enable register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ep_en_r <= EP_ENABLE_RESET;
        end else if (strobe_for(req.wr_valid, cmd_r, CMD_EP_ENABLE)) begin
            ep_en_r <= {7'b0000000, req.wr_data[EP_ENABLE_BIT]};
        end
    end

    // Gate for all non-control end-points
    assign endpoints_enabled = ep_en_r[EP_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Frame number capture from each received start of frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            frame_r <= 11'h000;
        end else if (sof_valid) begin
            frame_r <= sof_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select with clear interrupt decoding
    always_comb begin
        sel_clr_mask = 8'h00;
        for (int i = 0; i < NUM_EP; i++) begin
            if (req.cmd_valid && req.cmd == (CMD_SEL_CLR_BASE + 8'(i))) begin
                sel_clr_mask[i] = 1'b1;
            end
        end
    end

    // Interrupt source; a set in the same cycle wins over a clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_src_r <= INT_SRC_RESET;
        end else begin
            // End-point bits, cleared only by select with clear interrupt
            for (int i = 0; i < NUM_EP; i++) begin
                if (ep_event[i]) begin
                    int_src_r[i] <= 1'b1;
                end else if (sel_clr_mask[i]) begin
                    int_src_r[i] <= 1'b0;
                end
            end
            // Reserved bit held at zero
            int_src_r[6] <= 1'b0;
            // Device event bit from any device-level event
            if (dev_event || bus_reset_evt || suspend_toggle) begin
                int_src_r[INT_DEV_EVENT_BIT] <= 1'b1;
            end else if (status_read) begin
                int_src_r[INT_DEV_EVENT_BIT] <= 1'b0;
            end
        end
    end

    // Request while any non-reserved source bit stands
    assign irq = |{int_src_r[7], int_src_r[5:0]};

    ////////////////////////////////////////////////////////////////////////
    // Idle counter for suspend detection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idle_cnt_r <= 28'h000_0000;
        end else if (bus_activity) begin
            idle_cnt_r <= 28'h000_0000;
        end else if (idle_cnt_r < 28'(IDLE_CYCLES)) begin
            idle_cnt_r <= idle_cnt_r + 28'h000_0001;
        end
    end

    // Suspend enters past the idle limit, leaves on activity
    always_comb begin
        suspend_nxt = suspend_r;
        if (bus_activity) begin
            suspend_nxt = 1'b0;
        end else if (idle_cnt_r >= 28'(IDLE_CYCLES)) begin
            suspend_nxt = 1'b1;
        end
    end

    // Suspend state register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            suspend_r <= 1'b0;
        end else begin
            suspend_r <= suspend_nxt;
        end
    end

    // Suspend bit about to flip; feeds the change flag and the device event
    assign suspend_toggle = suspend_nxt != suspend_r;

    ////////////////////////////////////////////////////////////////////////
    // Remote wake-up pulse on a zero written while suspended, one cycle long
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= strobe_for(req.wr_valid, cmd_r, CMD_SET_STATUS) && suspend_r
                && !req.wr_data[ST_SUSPEND_BIT] && !wake_r;
        end
    end

    // Wake-up request toward the transceiver
    assign remote_wakeup = wake_r;

    ////////////////////////////////////////////////////////////////////////
    // Clear-on-read events; set wins over the read clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            susp_chg_r <= 1'b0;
            bus_rst_r <= 1'b0;
        end else begin
            if (suspend_toggle) begin
                susp_chg_r <= 1'b1;
            end else if (status_read) begin
                susp_chg_r <= 1'b0;
            end
            if (bus_reset_evt) begin
                bus_rst_r <= 1'b1;
            end else if (status_read) begin
                bus_rst_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Default-state pulse toward the address logic
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dflt_r <= 1'b0;
        end else begin
            dflt_r <= bus_reset_evt;
        end
    end

    // Return to address 0, unconfigured
    assign default_state = dflt_r;

    ////////////////////////////////////////////////////////////////////////
    // Debug error code; holds the last reported code
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            err_code_r <= ERR_RESET[3:0];
        end else if (err_rpt.valid) begin
            err_code_r <= err_rpt.code;
        end
    end

    // Error occurred flag; a new report wins over the transfer-start clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            err_flag_r <= ERR_RESET[ERR_FLAG_BIT];
        end else if (err_rpt.valid) begin
            err_flag_r <= 1'b1;
        end else if (transfer_start) begin
            err_flag_r <= 1'b0;
        end
    end
endmodule // udsr_status_regs

// ### udsr_host_model.sv
// Upstream host model: bus traffic, start of frame and bus reset.
// Assumes the bench steers it through quiet, sof_go and rst_go.
`timescale 1ns/10ps
module udsr_host_model (
    input wire logic clk,
    input wire logic quiet,
    input wire logic sof_go,
    input wire logic rst_go,
    input wire logic [10:0] frame,
    output logic bus_activity = 1'b0,
    output logic bus_reset_evt = 1'b0,
    output logic sof_valid = 1'b0,
    output logic [10:0] sof_frame = 11'h000
);
    // Traffic while not quiet; frame lines scramble outside a frame
    always_ff @(posedge clk) begin
        bus_activity <= !quiet;
        bus_reset_evt <= rst_go;
        sof_valid <= sof_go;
        sof_frame <= sof_go ? frame : ~sof_frame;
    end
endmodule // udsr_host_model

// ### udsr_status_regs_props.sv
// Checker for the status register block, bound to its top module.
// Assumes one clock with a synchronous active-low reset.
`timescale 1ns/10ps
module udsr_props
    import udsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire udsr_req_t req,
    input wire logic rd_valid,
    input wire logic bus_reset_evt,
    input wire logic [NUM_EP-1:0] ep_event,
    input wire logic dev_event,
    input wire logic remote_wakeup,
    input wire logic default_state,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // Read answers, interrupt request and event pulses
    a_read_answer: assert property (req.rd_req |=> rd_valid)
        else $error("read not answered");
    a_stray_read: assert property (rd_valid |-> $past(req.rd_req))
        else $error("read answer without request");
    a_ep_irq: assert property (|ep_event |-> ##[1:2] irq)
        else $error("end-point event left irq low");
    a_dev_irq: assert property (dev_event |-> ##[1:2] irq)
        else $error("device event left irq low");
    a_reset_irq: assert property (bus_reset_evt |-> ##[1:2] irq)
        else $error("bus reset left irq low");
    a_default_pulse: assert property (bus_reset_evt |=> default_state ##1 !default_state)
        else $error("default state pulse wrong");
    a_wake_cause: assert property (remote_wakeup |-> $past(req.wr_valid))
        else $error("wake-up without a write");
    a_wake_pulse: assert property (remote_wakeup |=> !remote_wakeup)
        else $error("wake-up longer than one cycle");
endmodule // udsr_props
bind udsr_status_regs udsr_props props (.clk, .reset_n, .req, .rd_valid, .bus_reset_evt,
    .ep_event, .dev_event, .remote_wakeup, .default_state, .irq);

// ### tb.sv
// Bench for the status register block with an upstream host model.
// Assumes a short idle count and a command port driven at rising edges.
`timescale 1ns/10ps
module tb;
    import udsr_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    udsr_req_t req = '0;
    logic [NUM_EP-1:0] ep_event = '0;
    logic dev_event = 1'b0;
    udsr_err_rpt_t err_rpt = '0;
    logic transfer_start = 1'b0;
    logic quiet = 1'b0;
    logic sof_go = 1'b0;
    logic rst_go = 1'b0;
    logic [10:0] frame = 11'h5a3;
    logic [7:0] rd_data;
    logic rd_valid, bus_activity, bus_reset_evt, sof_valid, endpoints_enabled;
    logic remote_wakeup, default_state, irq;
    logic [10:0] sof_frame;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    udsr_status_regs #(.IDLE_CYCLES(20)) dut (.clk, .reset_n, .req, .rd_data, .rd_valid,
        .bus_activity, .bus_reset_evt, .sof_valid, .sof_frame, .ep_event, .dev_event,
        .err_rpt, .transfer_start, .endpoints_enabled, .remote_wakeup, .default_state, .irq);
    udsr_host_model host (.clk, .quiet, .sof_go, .rst_go, .frame, .bus_activity,
        .bus_reset_evt, .sof_valid, .sof_frame);
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            $display("mismatch %0t timeout", $time);
            summarize();
        end
    end
    ////////////////////////////////////////
    task automatic summarize();
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Command byte, then data strobes, each held up to its taking edge
    task automatic cmd(input logic [7:0] c);
        @(posedge clk);
        req.cmd_valid <= 1'b1;
        req.cmd <= c;
        @(posedge clk);
        req.cmd_valid <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] exp, input bit en = 1'b1);
        @(posedge clk);
        req.rd_req <= 1'b1;
        @(posedge clk);
        req.rd_req <= 1'b0;
        #1;
        if (en)
            chk(rd_data, exp);
    endtask
    task automatic get(input logic [7:0] c, input logic [7:0] exp);
        cmd(c);
        rd(exp);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        cmd(c);
        @(posedge clk);
        req.wr_valid <= 1'b1;
        req.wr_data <= d;
        @(posedge clk);
        req.wr_valid <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        chk({7'h0, endpoints_enabled}, 8'h00);
        get(CMD_READ_INT, INT_SRC_RESET);
        get(CMD_GET_ERROR, ERR_RESET);
        get(CMD_GET_STATUS, 8'h00);
        wr(CMD_EP_ENABLE, 8'h01);
        chk({7'h0, endpoints_enabled}, 8'h01);
        wr(CMD_EP_ENABLE, 8'h00);
        chk({7'h0, endpoints_enabled}, 8'h00);
        @(posedge clk);
        ep_event <= 6'h3f;
        dev_event <= 1'b1;
        @(posedge clk);
        ep_event <= '0;
        dev_event <= 1'b0;
        get(CMD_READ_INT, 8'hbf);
        for (int i = 0; i < NUM_EP; i++) begin
            cmd(CMD_SEL_CLR_BASE + 8'(i));
            rd(8'h00, 1'b0);
            get(CMD_READ_INT, 8'hbf & ~((8'h02 << i) - 8'h01));
        end
        chk({7'h0, irq}, 8'h01);
        get(CMD_GET_STATUS, 8'h00);
        get(CMD_READ_INT, 8'h00);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        sof_go <= 1'b1;
        @(posedge clk);
        sof_go <= 1'b0;
        get(CMD_READ_FRAME, 8'ha3);
        rd(8'h05);
        get(CMD_READ_FRAME, 8'ha3);
        @(posedge clk);
        quiet <= 1'b1;
        repeat (40) @(posedge clk);
        get(CMD_GET_STATUS, 8'h0c);
        get(CMD_GET_STATUS, 8'h04);
        wr(CMD_SET_STATUS, 8'h04);
        chk({7'h0, remote_wakeup}, 8'h00);
        wr(CMD_SET_STATUS, 8'h00);
        chk({7'h0, remote_wakeup}, 8'h01);
        @(posedge clk);
        quiet <= 1'b0;
        repeat (4) @(posedge clk);
        get(CMD_GET_STATUS, 8'h08);
        wr(CMD_SET_STATUS, 8'h00);
        chk({7'h0, remote_wakeup}, 8'h00);
        @(posedge clk);
        rst_go <= 1'b1;
        @(posedge clk);
        rst_go <= 1'b0;
        @(posedge clk);
        #1 chk({7'h0, default_state}, 8'h01);
        get(CMD_GET_STATUS, 8'h10);
        get(CMD_GET_STATUS, 8'h00);
        for (int c = 1; c < 16; c++) begin
            @(posedge clk);
            err_rpt <= '{1'b1, udsr_err_t'(c)};
            @(posedge clk);
            err_rpt <= '0;
            get(CMD_GET_ERROR, 8'h10 | 8'(c));
        end
        @(posedge clk);
        transfer_start <= 1'b1;
        @(posedge clk);
        transfer_start <= 1'b0;
        get(CMD_GET_ERROR, 8'h0f);
        summarize();
    end
endmodule // tb
